//--- rtl/wbfc_bus_control.sv
// Functional notes
// - at most one filter path is ever switched in
// - filter switches come from a bus-written latch held until rewritten
// - same latch write also sets wideband enable and module enable
// - overload and underload kept as two separate comparator flags
// - each flag is gated by module enable before reaching the bus
// - status lines are open drain: float when good, drive low when bad
// - overload goes to the first status line, underload to the third
// - two 12-bit gain converter channels, one per attenuator
// - four addresses fill holding registers that do not touch outputs
// - fifth address copies all holding data to both outputs at once
// - selection chooses one of exactly three filter paths, or none when the code is not one-hot
`timescale 1ns/1ps
`default_nettype none
`include "wbfc_defs.svh"

module wbfc_bus_control
    import wbfc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] data_i,
    input wire logic overload_cmp_i,
    input wire logic underload_cmp_i,
    output logic [2:0] filter_path_o,
    output logic wide_en_o,
    output logic module_en_o,
    output logic [11:0] gain0_o,
    output logic [11:0] gain1_o,
    output logic overload_status_line_o,
    output logic overload_status_line_oe_o,
    output logic underload_status_line_o,
    output logic underload_status_line_oe_o
);
    wbfc_ctrl_type ctrl_reg;
    wbfc_dac_type hold_reg;
    wbfc_dac_type dac_reg;
    logic [2:0] path_next;
    logic overload_reg;
    logic underload_reg;

    function automatic logic hit(input logic [7:0] a);
        hit = wr_i && (addr_i == a);
    endfunction

    function automatic logic [2:0] one_hot_or_off(input logic [2:0] s);
        // refusing odd codes is safer than ever joining two filters
        one_hot_or_off = ($countones(s) == 1) ? s : 3'h0;
    endfunction

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_reg <= '0;
        end else if (hit(`WBFC_ADDR_SEL)) begin
            ctrl_reg.filter_sel <= data_i[`WBFC_SEL_LSB +: `WBFC_SEL_W];
            ctrl_reg.wide_en <= data_i[`WBFC_WIDE_BIT];
            ctrl_reg.module_en <= data_i[`WBFC_ENA_BIT];
        end
    end

    assign path_next = one_hot_or_off(ctrl_reg.filter_sel);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            filter_path_o <= 3'h0;
            wide_en_o <= 1'b0;
            module_en_o <= 1'b0;
        end else begin
            filter_path_o <= path_next;
            wide_en_o <= ctrl_reg.wide_en;
            module_en_o <= ctrl_reg.module_en;
        end
    end

    // holding writes never reach the attenuators directly
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_reg <= '0;
        end else begin
            if (hit(`WBFC_ADDR_CH0_LO)) hold_reg.ch0[7:0] <= data_i;
            if (hit(`WBFC_ADDR_CH0_HI)) hold_reg.ch0[11:8] <= data_i[3:0];
            if (hit(`WBFC_ADDR_CH1_LO)) hold_reg.ch1[7:0] <= data_i;
            if (hit(`WBFC_ADDR_CH1_HI)) hold_reg.ch1[11:8] <= data_i[3:0];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dac_reg <= '0;
        end else if (hit(`WBFC_ADDR_LOAD)) begin
            dac_reg <= hold_reg;
        end
    end

    assign gain0_o = dac_reg.ch0;
    assign gain1_o = dac_reg.ch1;

    // comparator levels registered separately; they share nothing
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            overload_reg <= 1'b0;
            underload_reg <= 1'b0;
        end else begin
            overload_reg <= overload_cmp_i;
            underload_reg <= underload_cmp_i;
        end
    end

    wbfc_status_driver u_over (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .fault_i(overload_reg),
        .enable_i(ctrl_reg.module_en),
        .line_o(overload_status_line_o),
        .line_oe_o(overload_status_line_oe_o)
    );

    wbfc_status_driver u_under (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .fault_i(underload_reg),
        .enable_i(ctrl_reg.module_en),
        .line_o(underload_status_line_o),
        .line_oe_o(underload_status_line_oe_o)
    );

    property p_one_path;
        @(posedge clk_i) disable iff (!resetn_i)
        $countones(filter_path_o) <= 1;
    endproperty
    a_one_path: assert property (p_one_path)
        else $error("more than one filter path on");

    property p_sel_holds;
        @(posedge clk_i) disable iff (!resetn_i)
        !hit(`WBFC_ADDR_SEL) |=> $stable(ctrl_reg);
    endproperty
    a_sel_holds: assert property (p_sel_holds)
        else $error("selection latch changed without write");

    property p_sel_write;
        @(posedge clk_i) disable iff (!resetn_i)
        hit(`WBFC_ADDR_SEL) |=> ##1 (module_en_o == $past(data_i[`WBFC_ENA_BIT], 2))
            && (wide_en_o == $past(data_i[`WBFC_WIDE_BIT], 2));
    endproperty
    a_sel_write: assert property (p_sel_write)
        else $error("enable bits not taken from selection write");

    property p_hold_quiet;
        @(posedge clk_i) disable iff (!resetn_i)
        !hit(`WBFC_ADDR_LOAD) |=> $stable(gain0_o) && $stable(gain1_o);
    endproperty
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("gain output moved without load");

    property p_load_both;
        @(posedge clk_i) disable iff (!resetn_i)
        hit(`WBFC_ADDR_LOAD) |=> (gain0_o == $past(hold_reg.ch0))
            && (gain1_o == $past(hold_reg.ch1));
    endproperty
    a_load_both: assert property (p_load_both)
        else $error("load did not update both channels");

    property p_hi_nibble;
        @(posedge clk_i) disable iff (!resetn_i)
        hit(`WBFC_ADDR_CH1_HI) |=> hold_reg.ch1[11:8] == $past(data_i[3:0]);
    endproperty
    a_hi_nibble: assert property (p_hi_nibble)
        else $error("high part not stored");

    property p_bad_sel_off;
        @(posedge clk_i) disable iff (!resetn_i)
        ($countones(ctrl_reg.filter_sel) != 1) |=> filter_path_o == 3'h0;
    endproperty
    a_bad_sel_off: assert property (p_bad_sel_off)
        else $error("invalid selection left a path on");

    // gating uses the internal enable one cycle ahead of module_en_o
    property p_over_line;
        @(posedge clk_i) disable iff (!resetn_i)
        overload_cmp_i |=> ##1 (overload_status_line_oe_o == $past(ctrl_reg.module_en));
    endproperty
    a_over_line: assert property (p_over_line)
        else $error("overload not on first status line");

    property p_under_line;
        @(posedge clk_i) disable iff (!resetn_i)
        underload_cmp_i |=> ##1 (underload_status_line_oe_o == $past(ctrl_reg.module_en));
    endproperty
    a_under_line: assert property (p_under_line)
        else $error("underload not on third status line");

    property p_flags_apart;
        @(posedge clk_i) disable iff (!resetn_i)
        1'b1 |=> (overload_reg == $past(overload_cmp_i))
            && (underload_reg == $past(underload_cmp_i));
    endproperty
    a_flags_apart: assert property (p_flags_apart)
        else $error("load flags not kept apart");

    property p_gate_off;
        @(posedge clk_i) disable iff (!resetn_i)
        !ctrl_reg.module_en |=> !overload_status_line_oe_o && !underload_status_line_oe_o;
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("fault reported while module disabled");

    property p_path_from_sel;
        @(posedge clk_i) disable iff (!resetn_i)
        ($countones(ctrl_reg.filter_sel) == 1) |=> filter_path_o == $past(ctrl_reg.filter_sel);
    endproperty
    a_path_from_sel: assert property (p_path_from_sel)
        else $error("valid selection not switched in");

    property p_lo_byte;
        @(posedge clk_i) disable iff (!resetn_i)
        hit(`WBFC_ADDR_CH0_LO) |=> hold_reg.ch0[7:0] == $past(data_i);
    endproperty
    a_lo_byte: assert property (p_lo_byte)
        else $error("low byte not held");

endmodule
`default_nettype wire

//--- rtl/wbfc_defs.svh
`ifndef WBFC_DEFS_SVH
`define WBFC_DEFS_SVH

`define WBFC_ADDR_W 8
`define WBFC_ADDR_SEL 8'h00
`define WBFC_ADDR_CH0_LO 8'h01
`define WBFC_ADDR_CH0_HI 8'h02
`define WBFC_ADDR_CH1_LO 8'h03
`define WBFC_ADDR_CH1_HI 8'h04
`define WBFC_ADDR_LOAD 8'h05
`define WBFC_SEL_LSB 0
`define WBFC_SEL_W 3
`define WBFC_WIDE_BIT 3
`define WBFC_ENA_BIT 4
`define WBFC_HI_W 4
`define WBFC_CTRL_RST 8'h00
`define WBFC_DAC_RST 12'h000

`endif

//--- rtl/wbfc_pkg.sv
package wbfc_pkg;

    typedef struct packed {
        logic [2:0] filter_sel;
        logic wide_en;
        logic module_en;
    } wbfc_ctrl_type;

    typedef struct packed {
        logic [11:0] ch1;
        logic [11:0] ch0;
    } wbfc_dac_type;

    typedef enum logic [1:0] {
        WBFC_IDLE,
        WBFC_HOLD,
        WBFC_APPLY
    } wbfc_load_state_type;

endpackage

//--- rtl/wbfc_status_driver.sv
`timescale 1ns/1ps
`default_nettype none
`include "wbfc_defs.svh"

module wbfc_status_driver
    import wbfc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic fault_i,
    input wire logic enable_i,
    output logic line_o,
    output logic line_oe_o
);
    // open drain: only the low level is ever driven; pullup gives good
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_oe_o <= 1'b0;
        end else begin
            line_oe_o <= fault_i & enable_i;
        end
    end

    assign line_o = 1'b0;

    property p_drive_follows;
        @(posedge clk_i) disable iff (!resetn_i)
        (fault_i && enable_i) |=> line_oe_o;
    endproperty
    a_drive_follows: assert property (p_drive_follows)
        else $error("status line not pulled low on fault");

    property p_disabled_quiet;
        @(posedge clk_i) disable iff (!resetn_i)
        !enable_i |=> !line_oe_o;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("status line driven while disabled");

endmodule
`default_nettype wire

//--- testbench/wbfc_status_bus.sv
`timescale 1ns/1ps
`default_nettype none

module wbfc_status_bus (
    input wire logic ov_i,
    input wire logic ov_oe_i,
    input wire logic un_i,
    input wire logic un_oe_i,
    output logic ov_level_o,
    output logic un_level_o
);
    // narrow conversion path is never enabled beside this module
    logic narrow_oe;
    assign narrow_oe = 1'b0;
    // pull-ups float the shared lines high when nobody drives them
    assign ov_level_o = !((ov_oe_i && !ov_i) || narrow_oe);
    assign un_level_o = !((un_oe_i && !un_i) || narrow_oe);
endmodule

`default_nettype wire

//--- testbench/wideband_filter_bus_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module wideband_filter_bus_control_tb;
    typedef struct packed {
        logic [7:0] d;
        logic [4:0] e;
    } wbfc_row_type;
    logic clk_i, resetn_i, wr_i, ov_cmp, un_cmp, ov, ov_oe, un, un_oe, ov_lvl, un_lvl;
    logic [7:0] addr_i, data_i;
    logic [2:0] path;
    logic wide, ena;
    logic [11:0] g0, g1;
    int n_mismatch, n_tests;
    // invalid codes must leave every path off, other bits still latch
    wbfc_row_type rows [6] = '{'{8'h11, 5'h05}, '{8'h0a, 5'h0a}, '{8'h14, 5'h11},
        '{8'h13, 5'h01}, '{8'h18, 5'h03}, '{8'hff, 5'h03}};

    wbfc_bus_control i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .wr_i(wr_i),
        .addr_i(addr_i), .data_i(data_i), .overload_cmp_i(ov_cmp),
        .underload_cmp_i(un_cmp), .filter_path_o(path), .wide_en_o(wide),
        .module_en_o(ena), .gain0_o(g0), .gain1_o(g1), .overload_status_line_o(ov),
        .overload_status_line_oe_o(ov_oe), .underload_status_line_o(un),
        .underload_status_line_oe_o(un_oe));
    wbfc_status_bus i_bus (.ov_i(ov), .ov_oe_i(ov_oe), .un_i(un), .un_oe_i(un_oe),
        .ov_level_o(ov_lvl), .un_level_o(un_lvl));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // leaves the strobe high so writes can run back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i = a;
        data_i = d;
        wr_i = 1'b1;
        tick(1);
    endtask

    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic status(input logic o, input logic u, input logic [1:0] exp);
        ov_cmp = o;
        un_cmp = u;
        tick(3);
        chk("lines", {22'h0, exp}, {22'h0, ov_lvl, un_lvl});
    endtask

    task automatic complete_run;
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        complete_run();
    end

    initial begin
        {resetn_i, wr_i, ov_cmp, un_cmp, addr_i, data_i} = '0;
        tick(8);
        resetn_i = 1'b1;
        chk("rst", 24'h0, {path, wide, ena, g0[6:0], 3'h0, ov_lvl, un_lvl} ^ 24'h3);
        foreach (rows[i]) begin
            wr(8'h00, rows[i].d);
            wr_i = 1'b0;
            tick(3);
            chk("sel", {19'h0, rows[i].e}, {19'h0, path, wide, ena});
        end
        wr(8'h00, 8'h12);
        wr(8'h06, 8'h01);
        wr_i = 1'b0;
        tick(3);
        chk("hold", 24'h09, {19'h0, path, wide, ena});
        wr(8'h01, 8'h34);
        wr(8'h02, 8'hf2);
        wr(8'h03, 8'hcd);
        wr(8'h04, 8'h0a);
        wr_i = 1'b0;
        tick(2);
        chk("hold_gain", 24'h0, {g1, g0});
        wr(8'h05, 8'h00);
        wr_i = 1'b0;
        tick(1);
        chk("gain", 24'hacd234, {g1, g0});
        status(1'b1, 1'b0, 2'b01);
        status(1'b0, 1'b1, 2'b10);
        status(1'b1, 1'b1, 2'b00);
        wr(8'h00, 8'h01);
        wr_i = 1'b0;
        status(1'b1, 1'b1, 2'b11);
        resetn_i = 1'b0;
        tick(1);
        resetn_i = 1'b1;
        chk("rst2", 24'h0, {path, wide, ena, g0[11:0], 7'h0});
        complete_run();
    end
endmodule

`default_nettype wire
